/* File: verilog/ooc_regs.vh */
// constants for the cycle-skip switch controller
// Function
// - sample feedback once per cycle, then switch on
// - disabled sample keeps switch off whole cycle
// - started cycle completes, feedback changes ignored
// - cycle clock runs continuously, always sampling
// - feedback disable hysteresis: 50 uA, 40 uA
// - current ceiling ends pulse for that cycle
// - base rate 44 kHz on lower variants
// - higher variant runs 130 kHz, build parameter
// - supply collapse holds switch off, no glitches
// - decisions start after 0.3 ms start-up delay
// - max on-time signal ends pulse at 67%
// - skipping doubles rate, except higher variant
// - blank current ceiling after each turn-on
// - undervoltage off below 5.1V, on at 5.8V
`ifndef OOC_REGS_VH
`define OOC_REGS_VH
`define OOC_CLK_MHZ 100
`define OOC_CLK_HZ 100000000
`define OOC_FREQ_LOW_HZ 44000
`define OOC_FREQ_HIGH_HZ 130000
`define OOC_MAX_ON_TIME_SIGNAL_PCT 67
`define OOC_PCT_FULL 100
`define OOC_NS_PER_US 1000
`define OOC_STARTUP_NS 300000
`define OOC_LEB_NS 200
`define OOC_STARTUP_CYCLES ((`OOC_STARTUP_NS * `OOC_CLK_MHZ) / `OOC_NS_PER_US)
`define OOC_LEB_CYCLES ((`OOC_LEB_NS * `OOC_CLK_MHZ + `OOC_NS_PER_US - 1) / `OOC_NS_PER_US)
`define OOC_SYNC_W 6
`define OOC_BIT_FB_HI 0
`define OOC_BIT_FB_LO 1
`define OOC_BIT_ILIM 2
`define OOC_BIT_SUP_HI 3
`define OOC_BIT_SUP_LO 4
`define OOC_BIT_LINE 5
`endif

/* File: verilog/ooc_sync2.v */
// two-flop synchroniser for comparator levels
`timescale 1ns/100ps
module ooc_sync2 #(
   parameter WIDTH = 1
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;
reg [WIDTH-1:0] sync_r;

// first stage feeds only the second stage
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      meta_r <= {WIDTH{1'h0}};
      sync_r <= {WIDTH{1'h0}};
   end
   else
   begin
      meta_r <= async_in;
      sync_r <= meta_r;
   end
end

assign sync_out = sync_r;

endmodule

/* File: verilog/ooc_switch_ctrl.v */
// cycle-skip on/off switch controller, oscillator and pulse sequencing
`timescale 1ns/100ps
`include "ooc_regs.vh"
module ooc_switch_ctrl #(
   parameter FAST_VARIANT = 0,
   parameter CNT_W = 16,
   parameter START_W = 16,
   parameter STARTUP_CYCLES = `OOC_STARTUP_CYCLES,
   parameter LEB_CYCLES = `OOC_LEB_CYCLES
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire fb_over_hi_thr,
   input wire fb_under_lo_thr,
   input wire switch_current_ceiling,
   input wire supply_above_restart,
   input wire supply_below_dropout,
   input wire line_above_collapse,
   output wire switch_on,
   output wire cycle_start,
   output wire max_on_time_signal,
   output wire skip_mode,
   output wire fb_disabled,
   output wire run_enable
);

// period lengths in ref_clk cycles; both periods are fixed at build time, picked per cycle
localparam integer FULL_HZ = FAST_VARIANT ? `OOC_FREQ_HIGH_HZ : `OOC_FREQ_LOW_HZ;
localparam integer PER_FULL_I = `OOC_CLK_HZ / FULL_HZ;
localparam integer PER_FAST_I = FAST_VARIANT ? PER_FULL_I : PER_FULL_I / 2;
localparam integer MAX_ON_TIME_SIGNAL_FULL_I = (PER_FULL_I * `OOC_MAX_ON_TIME_SIGNAL_PCT) / `OOC_PCT_FULL;
localparam integer MAX_ON_TIME_SIGNAL_FAST_I = (PER_FAST_I * `OOC_MAX_ON_TIME_SIGNAL_PCT) / `OOC_PCT_FULL;
localparam [CNT_W-1:0] PER_FULL = PER_FULL_I[CNT_W-1:0];
localparam [CNT_W-1:0] PER_FAST = PER_FAST_I[CNT_W-1:0];
localparam [CNT_W-1:0] MAX_ON_TIME_SIGNAL_FULL = MAX_ON_TIME_SIGNAL_FULL_I[CNT_W-1:0];
localparam [CNT_W-1:0] MAX_ON_TIME_SIGNAL_FAST = MAX_ON_TIME_SIGNAL_FAST_I[CNT_W-1:0];
localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'h0}}, 1'h1};
localparam [CNT_W-1:0] LEB_LEN = LEB_CYCLES[CNT_W-1:0];
localparam [START_W-1:0] START_LEN = STARTUP_CYCLES[START_W-1:0];
localparam [START_W-1:0] START_ONE = {{(START_W-1){1'h0}}, 1'h1};

wire [`OOC_SYNC_W-1:0] raw_in;
wire [`OOC_SYNC_W-1:0] syn_in;
wire fb_hi_s;
wire fb_lo_s;
wire ilim_s;
wire sup_hi_s;
wire sup_lo_s;
wire line_ok_s;

reg [CNT_W-1:0] osc_cnt_r;
reg [CNT_W-1:0] period_r;
reg [CNT_W-1:0] max_on_time_signal_r;
reg [CNT_W-1:0] blank_cnt_r;
reg [START_W-1:0] start_cnt_r;
reg started_r;
reg uv_r;
reg fb_disabled_r;
reg switch_on_r;
reg cycle_start_r;
reg max_on_time_signal_sig_r;
reg skip_r;

wire cycle_end;
wire run_ok;
wire take_cycle;
wire blank_done;
wire end_pulse;

// every comparator level comes from the analog side, asynchronous to ref_clk
assign raw_in[`OOC_BIT_FB_HI] = fb_over_hi_thr;
assign raw_in[`OOC_BIT_FB_LO] = fb_under_lo_thr;
assign raw_in[`OOC_BIT_ILIM] = switch_current_ceiling;
assign raw_in[`OOC_BIT_SUP_HI] = supply_above_restart;
assign raw_in[`OOC_BIT_SUP_LO] = supply_below_dropout;
assign raw_in[`OOC_BIT_LINE] = line_above_collapse;

ooc_sync2 #(
   .WIDTH(`OOC_SYNC_W)
) u_sync (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .async_in(raw_in),
   .sync_out(syn_in)
);

assign fb_hi_s = syn_in[`OOC_BIT_FB_HI];
assign fb_lo_s = syn_in[`OOC_BIT_FB_LO];
assign ilim_s = syn_in[`OOC_BIT_ILIM];
assign sup_hi_s = syn_in[`OOC_BIT_SUP_HI];
assign sup_lo_s = syn_in[`OOC_BIT_SUP_LO];
assign line_ok_s = syn_in[`OOC_BIT_LINE];

// start-up delay; counter stops once done
// start-up delay gate
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      start_cnt_r <= {START_W{1'h0}};
      started_r <= 1'h0;
   end
   else if (!started_r)
   begin
      if (start_cnt_r == START_LEN - START_ONE)
         started_r <= 1'h1;
      else
         start_cnt_r <= start_cnt_r + START_ONE;
   end
end

// undervoltage latch, starts tripped so the supply must first reach restart
// undervoltage hysteresis latch
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
      uv_r <= 1'h1;
   else if (sup_lo_s)
      uv_r <= 1'h1;  // dropout wins over restart
   else if (sup_hi_s)
      uv_r <= 1'h0;
end

// feedback threshold hysteresis: trip on high, release only under low
// feedback disable hysteresis
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
      fb_disabled_r <= 1'h0;
   else if (!fb_disabled_r && fb_hi_s)
      fb_disabled_r <= 1'h1;
   else if (fb_disabled_r && fb_lo_s)
      fb_disabled_r <= 1'h0;
end

assign run_ok = started_r & ~uv_r & line_ok_s;

// oscillator wraps on the last count of the current period
assign cycle_end = (osc_cnt_r == period_r - CNT_ONE);
assign take_cycle = cycle_end & run_ok & ~fb_disabled_r;

// free-running oscillator; period chosen per cycle at the boundary
// oscillator never stops
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      osc_cnt_r <= {CNT_W{1'h0}};
      period_r <= PER_FULL;
      max_on_time_signal_r <= MAX_ON_TIME_SIGNAL_FULL;
      skip_r <= 1'h0;
      cycle_start_r <= 1'h0;
   end
   else
   begin
      cycle_start_r <= cycle_end;
      if (cycle_end)
      begin
         osc_cnt_r <= {CNT_W{1'h0}};
         skip_r <= ~take_cycle;
         if (take_cycle)
         begin
            period_r <= PER_FULL;
            max_on_time_signal_r <= MAX_ON_TIME_SIGNAL_FULL;
         end
         else
         begin
            period_r <= PER_FAST;
            max_on_time_signal_r <= MAX_ON_TIME_SIGNAL_FAST;
         end
      end
      else
         osc_cnt_r <= osc_cnt_r + CNT_ONE;
   end
end

// max on-time signal: high over the first fraction of each period
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
      max_on_time_signal_sig_r <= 1'h0;
   else if (cycle_end)
      max_on_time_signal_sig_r <= 1'h1;
   else if (osc_cnt_r == max_on_time_signal_r - CNT_ONE)
      max_on_time_signal_sig_r <= 1'h0;
end

// blanking counter restarts at turn-on and saturates
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
      blank_cnt_r <= {CNT_W{1'h0}};
   else if (take_cycle)
      blank_cnt_r <= {CNT_W{1'h0}};
   else if (switch_on_r && blank_cnt_r != LEB_LEN)
      blank_cnt_r <= blank_cnt_r + CNT_ONE;
end

assign blank_done = (blank_cnt_r == LEB_LEN);

// pulse end: current ceiling, max on-time, or loss of supply
assign end_pulse = (blank_done & ilim_s) |
                   (osc_cnt_r == max_on_time_signal_r - CNT_ONE) |
                   ~run_ok;

// switch drive; feedback is only looked at through take_cycle
// feedback ignored mid-cycle
always @(posedge ref_clk or negedge rst_n)
begin
   if (!rst_n)
      switch_on_r <= 1'h0;
   else if (take_cycle)
      switch_on_r <= 1'h1;
   else if (cycle_end)
      switch_on_r <= 1'h0;
   else if (switch_on_r && end_pulse)
      switch_on_r <= 1'h0;
end

// the partner keeps enable high below regulation; nothing here depends on it
// beyond treating its pull-down through the hysteresis above
assign switch_on = switch_on_r;
assign cycle_start = cycle_start_r;
assign max_on_time_signal = max_on_time_signal_sig_r;
assign skip_mode = skip_r;
assign fb_disabled = fb_disabled_r;
assign run_enable = run_ok;

endmodule

/* File: test/ooc_switch_props.sv */
// port checks for the cycle-skip switch controller
`timescale 1ns/100ps
module ooc_switch_props #(
   parameter FAST_VARIANT = 0
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire fb_over_hi_thr,
   input wire fb_under_lo_thr,
   input wire line_above_collapse,
   input wire switch_on,
   input wire cycle_start,
   input wire max_on_time_signal,
   input wire skip_mode,
   input wire fb_disabled,
   input wire run_enable
);
   localparam PF = FAST_VARIANT ? 769 : 2272;
   localparam PS = FAST_VARIANT ? 769 : 1136;
   reg [15:0] gap_r;
   reg seen_r;
   reg took_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // cycles since last boundary; first one after reset is not judged
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         gap_r <= 16'h0;
         seen_r <= 1'h0;
         took_r <= 1'h0;
      end
      else if (cycle_start)
      begin
         gap_r <= 16'h1;
         seen_r <= 1'h1;
         took_r <= switch_on;
      end
      else
         gap_r <= gap_r + 16'h1;
   take_on_a: assert property (
      cycle_start && $past(run_enable) && !$past(fb_disabled) |-> switch_on)
      else $error("no pulse");
   skip_off_a: assert property (cycle_start && $past(fb_disabled)
      |-> !switch_on && skip_mode) else $error("skip lost");
   max_on_time_signal_cap_a: assert property (switch_on |-> max_on_time_signal)
      else $error("on too long");
   blank_hold_a: assert property ($rose(switch_on)
      |-> (switch_on || !run_enable) [*8]) else $error("blank cut");
   gate_off_a: assert property (!run_enable |=> !switch_on)
      else $error("on while off");
   line_drop_a: assert property (!line_above_collapse [*3] |-> !run_enable)
      else $error("line gone");
   fb_set_a: assert property ((fb_over_hi_thr && !fb_under_lo_thr) [*4]
      |-> fb_disabled) else $error("fb not set");
   period_a: assert property (cycle_start && seen_r
      |-> gap_r == PF || !took_r && gap_r == PS) else $error("bad period");
endmodule
bind ooc_switch_ctrl ooc_switch_props #(
   .FAST_VARIANT(FAST_VARIANT)
) props (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .fb_over_hi_thr(fb_over_hi_thr),
   .fb_under_lo_thr(fb_under_lo_thr),
   .line_above_collapse(line_above_collapse),
   .switch_on(switch_on),
   .cycle_start(cycle_start),
   .max_on_time_signal(max_on_time_signal),
   .skip_mode(skip_mode),
   .fb_disabled(fb_disabled),
   .run_enable(run_enable)
);

/* File: test/ooc_opto_model.sv */
// feedback optocoupler model: sink level to comparator outputs
`timescale 1ns/100ps
module ooc_opto_model
(
   input wire [1:0] pull_lvl,
   output wire fb_over_hi_thr,
   output wire fb_under_lo_thr
);
   assign fb_over_hi_thr = (pull_lvl == 2'h2);
   // mid band shows neither side, so hysteresis decides
   assign fb_under_lo_thr = (pull_lvl == 2'h0);
endmodule

/* File: test/tb_ooc_switch_ctrl.sv */
// bench for the cycle-skip switch controller
`timescale 1ns/100ps
module tb_ooc_switch_ctrl;
   reg ref_clk = 1'h0;
   reg rst_n = 1'h0;
   reg switch_current_ceiling = 1'h0;
   reg supply_above_restart = 1'h1;
   reg supply_below_dropout = 1'h0;
   reg line_above_collapse = 1'h1;
   reg [1:0] pull_lvl = 2'h0;
   wire fb_over_hi_thr, fb_under_lo_thr, switch_on, cycle_start;
   wire max_on_time_signal, skip_mode, fb_disabled, run_enable;
   wire fast_on, fast_start, fast_skip;
   integer failures = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer n;
   ooc_switch_ctrl #(
      .STARTUP_CYCLES(16)
   ) DUT (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .fb_over_hi_thr(fb_over_hi_thr),
      .fb_under_lo_thr(fb_under_lo_thr),
      .switch_current_ceiling(switch_current_ceiling),
      .supply_above_restart(supply_above_restart),
      .supply_below_dropout(supply_below_dropout),
      .line_above_collapse(line_above_collapse),
      .switch_on(switch_on),
      .cycle_start(cycle_start),
      .max_on_time_signal(max_on_time_signal),
      .skip_mode(skip_mode),
      .fb_disabled(fb_disabled),
      .run_enable(run_enable)
   );
   // higher-rate build on the same inputs, to see its period and no doubling
   ooc_switch_ctrl #(
      .FAST_VARIANT(1),
      .STARTUP_CYCLES(16)
   ) DUT_FAST (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .fb_over_hi_thr(fb_over_hi_thr),
      .fb_under_lo_thr(fb_under_lo_thr),
      .switch_current_ceiling(switch_current_ceiling),
      .supply_above_restart(supply_above_restart),
      .supply_below_dropout(supply_below_dropout),
      .line_above_collapse(line_above_collapse),
      .switch_on(fast_on),
      .cycle_start(fast_start),
      .max_on_time_signal(),
      .skip_mode(fast_skip),
      .fb_disabled(),
      .run_enable()
   );
   ooc_opto_model opto (
      .pull_lvl(pull_lvl),
      .fb_over_hi_thr(fb_over_hi_thr),
      .fb_under_lo_thr(fb_under_lo_thr)
   );
   initial forever #5 ref_clk = ~ref_clk;
   // hang guard, well above the ~20.5k cycles needed
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 60000)
      begin
         failures = failures + 1;
         test_done;
      end
   end
   task tick(input integer k);
      repeat (k) @(posedge ref_clk) #1;
   endtask
   task check(input [15:0] seen, input [15:0] want);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== want)
      begin
         failures = failures + 1;
         $display("BAD %0t %0d not %0d", $time, seen, want);
      end
   end
   endtask
   // 0 waits boundary, 1 times the pulse, 2 waits run, 3 and 4 as 0 and 1 on the fast unit
   task hold(input integer sel);
   begin
      n = 0;
      while ((sel == 0 ? !cycle_start : sel == 1 ? switch_on : sel == 2 ? !run_enable :
              sel == 3 ? !fast_start : fast_on) === 1'h1 && n < 3000)
      begin
         tick(1);
         n = n + 1;
      end
   end
   endtask
   task t_start;
   begin
      tick(6);
      rst_n = 1'h1;
      hold(2);
      check(n > 15 && n < 21, 1);
   end
   endtask
   task t_take;
   begin
      hold(0);
      tick(1);
      hold(0);
      check(n + 1, 2272);
      check(switch_on, 1);
      check(max_on_time_signal, 1);
      hold(1);
      check(n, 1522);
      check(max_on_time_signal, 0);
   end
   endtask
   // fast build: 769-cycle period both when taking and when skipping
   task t_fast;
   begin
      hold(3);
      tick(1);
      hold(3);
      check(n + 1, 769);
      check(fast_on, 1);
      hold(4);
      check(n, 515);
      pull_lvl = 2'h2;
      hold(3);
      check({fast_on, fast_skip}, 1);
      tick(1);
      hold(3);
      check(n + 1, 769);
      pull_lvl = 2'h0;
   end
   endtask
   task t_ilim;
   begin
      hold(0);
      switch_current_ceiling = 1'h1;
      hold(1);
      check(n > 20 && n < 25, 1);
      switch_current_ceiling = 1'h0;
   end
   endtask
   task t_skip;
   begin
      hold(0);
      tick(5);
      pull_lvl = 2'h2;
      hold(1);
      check(n + 5, 1522);
      hold(0);
      check({switch_on, skip_mode, fb_disabled}, 3);
      pull_lvl = 2'h1;
      tick(1);
      hold(0);
      check(n + 1, 1136);
      check(fb_disabled, 1);
      pull_lvl = 2'h0;
      tick(1);
      hold(0);
      check(switch_on, 1);
      pull_lvl = 2'h1;
      tick(8);
      check(fb_disabled, 0);
      pull_lvl = 2'h0;
   end
   endtask
   task t_power;
   begin
      hold(0);
      tick(3);
      line_above_collapse = 1'h0;
      tick(3);
      check({run_enable, switch_on}, 0);
      n = 0;
      repeat (2400)
      begin
         tick(1);
         n = n + (switch_on !== 1'h0);
      end
      check(n, 0);
      line_above_collapse = 1'h1;
      supply_above_restart = 1'h0;
      supply_below_dropout = 1'h1;
      tick(4);
      supply_below_dropout = 1'h0;
      tick(4);
      check(run_enable, 0);
      supply_above_restart = 1'h1;
      tick(4);
      check(run_enable, 1);
   end
   endtask
   task t_reset;
   begin
      hold(0);
      rst_n = 1'h0;
      #1 check(switch_on, 0);
      t_start;
   end
   endtask
   task test_done;
   begin
      $display("failures %0d compares %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      t_start;
      t_take;
      t_ilim;
      t_skip;
      t_fast;
      t_power;
      t_reset;
      test_done;
   end
endmodule
